// [hdl/mcdl_consts.svh]
// Constants for the deferred-error logging bank: offsets, fields, resets.
// Assumes inclusion by the package, the bank module and the testbench.
`ifndef MCDL_CONSTS_SVH
`define MCDL_CONSTS_SVH

// ****************************************
// Register indices (bus address bits 7:1)
// ****************************************
`define MCDL_IDX_BANK_CTL      8'h00
`define MCDL_IDX_STATUS        8'h01
`define MCDL_IDX_ADDR          8'h02
`define MCDL_IDX_MISC0         8'h03
`define MCDL_IDX_CONFIG        8'h04
`define MCDL_IDX_SYND          8'h06
`define MCDL_IDX_DESTAT        8'h08
`define MCDL_IDX_DEADDR        8'h09
`define MCDL_IDX_MISC1         8'h0A
`define MCDL_IDX_SYND1         8'h0E
`define MCDL_IDX_GCAP          8'h10
`define MCDL_IDX_GCTL          8'h11
`define MCDL_IDX_CORE          8'h12
`define MCDL_IDX_THRESH        8'h13

// ****************************************
// Status field positions
// ****************************************
`define MCDL_ST_VALID          63
`define MCDL_ST_OVER           62
`define MCDL_ST_UC             61
`define MCDL_ST_ADDR_VALID_FLAG          58
`define MCDL_ST_SYNDROME_VALID_FLAG          53
`define MCDL_ST_DEFERRED       44

// ****************************************
// Config field positions
// ****************************************
`define MCDL_CF_INTEN          40
`define MCDL_CF_IRQSEL_HI      38
`define MCDL_CF_IRQSEL_LO      37
`define MCDL_CF_DUALLOG        34
`define MCDL_CF_ERRCODE_CAP    7
`define MCDL_CF_DEFLOG_SUP     2

// ****************************************
// Global capability fields and core control bits
// ****************************************
`define MCDL_GCAP_GLOBAL_CTL_PRESENT         8
`define MCDL_CORE_MCE          0
`define MCDL_CORE_SHUT         1
`define MCDL_CORE_EXC          2

// ****************************************
// Deferred interrupt select encodings and resets
// ****************************************
`define MCDL_IRQ_NONE          2'b00
`define MCDL_IRQ_LOCAL         2'b01
`define MCDL_IRQ_SMI           2'b10
`define MCDL_RST_CTL           64'h0000_0000_0000_0000
`define MCDL_RST_THRESH        16'h0000

`endif

// [hdl/mcdl_pkg.sv]
// Types for the deferred-error logging bank.
// Assumes mcdl_consts.svh is on the include path.
`include "mcdl_consts.svh"
package mcdl_pkg;

    // ****************************************
    // Error event from an on-chip detector
    // ****************************************
    typedef struct packed {
        logic        valid;
        logic [1:0]  kind;
        logic        addr_ok;
        logic        synd_ok;
        logic [31:0] code;
        logic [63:0] addr;
        logic [63:0] synd;
        logic [63:0] misc;
    } mcdl_err_t;

    typedef enum logic [1:0] {
        MCDL_CORRECTED   = 2'b00,
        MCDL_DEFERRED    = 2'b01,
        MCDL_UNCORRECTED = 2'b10
    } mcdl_kind_t;

    // Wishbone slave-side reply
    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } mcdl_wb_rsp_t;

    typedef enum logic [1:0] {
        MCDL_RUN      = 2'b00,
        MCDL_EXC      = 2'b01,
        MCDL_SHUTDOWN = 2'b11
    } mcdl_core_t;

    typedef struct packed {
        logic [63:0]      bank_ctl;
        logic [63:0]      status;
        logic [63:0]      addr;
        logic [63:0]      misc0;
        logic [63:0]      config_r;
        logic [63:0]      synd;
        logic [63:0]      destat;
        logic [63:0]      deaddr;
        logic [3:0][63:0] misc_x;
        logic [1:0][63:0] synd_x;
        logic [63:0]      gctl;
        logic             mc_exception_enable;
        mcdl_core_t       core;
        logic [15:0]      thresh;
        logic [15:0]      ce_count;
        mcdl_wb_rsp_t     wb;
        logic             irq_local;
        logic             irq_smi;
        logic             irq_thresh;
    } mcdl_state_t;

endpackage

// [hdl/mcdl_bank.sv]
// One error-reporting bank with deferred-error status and address logging.
// Assumes a classic Wishbone master on the core clock and error pulses on clk_i.
//
// Notes on behaviour
// - Deferred record survives later severe errors
// - Deferred errors written to deferred status when it holds no valid record; the bank logs one only while its bank_ctl bit enables the deferred kind
// - Bit 63 marks valid deferred record
// - Bit 62 marks lost further deferred error
// - Bit 58 marks deferred address present
// - Bit 53 marks syndrome present
// - Bit 44 marks deferred class
// - Error codes present only when capable
// - Deferred address meaningful with valid and addr_valid_flag
// - Deferred address layout matches primary address
// - Extra misc registers hardware-written only
// - Extra syndromes valid with either syndrome_valid_flag
// - Reporting enables cleared after reset
// - Capability bit reports global control present
// - Capability count reports implemented banks
// - Control bits enable error types individually
// - Writing zeros clears the status record
// - Exception disabled means core shutdown
// - Enabled uncorrected error raises exception
// - Interrupts on deferred or threshold reached
// - Logs not cleared by warm reset
// - Dual-log enable adds primary logging
// - Two-bit field picks deferred interrupt kind
//
// The placing of the registers and the Wishbone register port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "mcdl_consts.svh"
module mcdl_bank
    import mcdl_pkg::*;
#(
    parameter int          BANK_COUNT = 1,
    parameter logic        ERRCODE_CAP = 1'b1,
    parameter logic        GCTL_PRESENT = 1'b1
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        warm_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    input  wire mcdl_err_t   err_i,
    output logic             mc_exception_o,
    output logic             shutdown_o,
    output logic             irq_local_o,
    output logic             irq_smi_o,
    output logic             irq_thresh_o
);

    mcdl_state_t s_reg;
    mcdl_state_t s_next;

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [31:0] merge32(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [63:0] wr64(input logic [63:0] old, input logic hi,
                                         input logic [31:0] nw, input logic [3:0] sel);
        logic [63:0] r;
        r = old;
        if (hi) begin
            r[63:32] = merge32(old[63:32], nw, sel);
        end else begin
            r[31:0] = merge32(old[31:0], nw, sel);
        end
        return r;
    endfunction

    function automatic logic [63:0] make_status(input mcdl_err_t e, input logic cap);
        logic [63:0] r;
        r = '0;
        r[`MCDL_ST_VALID]    = 1'b1;
        r[`MCDL_ST_UC]       = (e.kind == MCDL_UNCORRECTED);
        r[`MCDL_ST_ADDR_VALID_FLAG]    = e.addr_ok;
        r[`MCDL_ST_SYNDROME_VALID_FLAG]    = e.synd_ok;
        r[`MCDL_ST_DEFERRED] = (e.kind == MCDL_DEFERRED);
        if (cap) begin
            r[31:0] = e.code;
        end
        return r;
    endfunction

    // Register read decode by index; unmapped indices read as zero
    function automatic logic [63:0] read_reg(input mcdl_state_t s, input logic [6:0] idx,
                                             input logic [63:0] cap_word);
        logic [63:0] r;
        r = '0;
        case ({1'b0, idx})
            `MCDL_IDX_BANK_CTL: r = s.bank_ctl;
            `MCDL_IDX_STATUS:   r = s.status;
            `MCDL_IDX_ADDR:     r = s.addr;
            `MCDL_IDX_MISC0:    r = s.misc0;
            `MCDL_IDX_CONFIG:   r = s.config_r;
            `MCDL_IDX_SYND:     r = s.synd;
            `MCDL_IDX_DESTAT:   r = s.destat;
            `MCDL_IDX_DEADDR:   r = s.deaddr;
            `MCDL_IDX_GCAP:     r = cap_word;
            `MCDL_IDX_GCTL:     r = s.gctl;
            `MCDL_IDX_CORE:     r = {62'h0, s.core == MCDL_SHUTDOWN, s.mc_exception_enable};
            `MCDL_IDX_THRESH:   r = {s.ce_count, 32'h0, s.thresh};
            default: begin
                if (idx >= 7'(`MCDL_IDX_MISC1) && idx < 7'(`MCDL_IDX_SYND1)) begin
                    r = s.misc_x[2'(idx - 7'(`MCDL_IDX_MISC1))];
                end else if (idx == 7'(`MCDL_IDX_SYND1)) begin
                    r = s.synd_x[0];
                end else if (idx == 7'(`MCDL_IDX_SYND1) + 7'd1) begin
                    r = s.synd_x[1];
                end else begin
                    r = '0;
                end
            end
        endcase
        return r;
    endfunction

    // Escalation target of an enabled uncorrected error
    function automatic mcdl_core_t next_core(input mcdl_core_t now, input logic mce_on);
        mcdl_core_t r;
        // A second exception while one is pending also ends in shutdown
        if (!mce_on || now != MCDL_RUN) begin
            r = MCDL_SHUTDOWN;
        end else begin
            r = MCDL_EXC;
        end
        return r;
    endfunction

    // ****************************************
    // Bus decode: 64-bit registers as two 32-bit words
    // ****************************************
    logic [6:0]  reg_idx;
    logic        hi_word;
    logic        access;
    logic [63:0] gcap;

    assign reg_idx = wb_adr_i[7:1];
    assign hi_word = wb_adr_i[0];
    assign access  = wb_cyc_i && wb_stb_i && !s_reg.wb.ack;
    assign gcap    = {55'h0, GCTL_PRESENT, 8'(BANK_COUNT)};

    always_comb begin
        logic [63:0] rd;
        logic        ev;
        logic        enabled;
        logic        cap;
        logic        wr;
        rd = '0;
        ev = err_i.valid && s_reg.bank_ctl[err_i.kind];
        enabled = ev && s_reg.gctl[0];
        s_next = s_reg;
        s_next.wb.ack = access;
        s_next.irq_local = 1'b0;
        s_next.irq_smi = 1'b0;
        s_next.irq_thresh = 1'b0;
        wr = access && wb_we_i;
        cap = ERRCODE_CAP;

        // ****************************************
        // Reads
        // ****************************************
        rd = read_reg(s_reg, reg_idx, gcap);
        s_next.wb.dat = access ? (hi_word ? rd[63:32] : rd[31:0]) : s_reg.wb.dat;

        // ****************************************
        // Writes; misc and syndrome extras are hardware-only
        // ****************************************
        if (wr) begin
            case ({1'b0, reg_idx})
                `MCDL_IDX_BANK_CTL: s_next.bank_ctl = wr64(s_reg.bank_ctl, hi_word,
                                                           wb_dat_i, wb_sel_i);
                `MCDL_IDX_STATUS:   s_next.status = wr64(s_reg.status, hi_word,
                                                         wb_dat_i, wb_sel_i);
                `MCDL_IDX_ADDR:     s_next.addr = wr64(s_reg.addr, hi_word, wb_dat_i, wb_sel_i);
                `MCDL_IDX_CONFIG: begin
                    s_next.config_r = wr64(s_reg.config_r, hi_word, wb_dat_i, wb_sel_i);
                    s_next.config_r[`MCDL_CF_ERRCODE_CAP] = cap;
                    s_next.config_r[`MCDL_CF_DEFLOG_SUP] = 1'b1;
                end
                `MCDL_IDX_DESTAT:   s_next.destat = wr64(s_reg.destat, hi_word,
                                                         wb_dat_i, wb_sel_i);
                `MCDL_IDX_DEADDR:   s_next.deaddr = wr64(s_reg.deaddr, hi_word, wb_dat_i, wb_sel_i);
                `MCDL_IDX_GCTL:     s_next.gctl = wr64(s_reg.gctl, hi_word, wb_dat_i, wb_sel_i);
                `MCDL_IDX_CORE: begin
                    if (!hi_word && wb_sel_i[0]) begin
                        s_next.mc_exception_enable = wb_dat_i[`MCDL_CORE_MCE];
                        if (wb_dat_i[`MCDL_CORE_EXC] && s_reg.core == MCDL_EXC) begin
                            s_next.core = MCDL_RUN;
                        end
                    end
                end
                `MCDL_IDX_THRESH: begin
                    if (!hi_word) begin
                        s_next.thresh = 16'(merge32({16'h0, s_reg.thresh}, wb_dat_i, wb_sel_i));
                        s_next.ce_count = '0;
                    end
                end
                default: ;
            endcase
        end

        // ****************************************
        // Error capture: hardware wins over a same-cycle software write
        // ****************************************
        if (ev) begin
            s_next.misc0 = err_i.misc;
            s_next.misc_x = {4{err_i.misc}};
            if (err_i.synd_ok) begin
                s_next.synd = err_i.synd;
                s_next.synd_x = {2{err_i.synd}};
            end
            if (err_i.kind == MCDL_DEFERRED) begin
                if (s_reg.destat[`MCDL_ST_VALID]) begin
                    s_next.destat[`MCDL_ST_OVER] = 1'b1;
                end else begin
                    s_next.destat = make_status(err_i, cap);
                    s_next.deaddr = err_i.addr_ok ? err_i.addr : '0;
                end
                if (s_reg.config_r[`MCDL_CF_DUALLOG]) begin
                    if (!s_reg.status[`MCDL_ST_VALID]) begin
                        s_next.status = make_status(err_i, cap);
                        s_next.addr = err_i.addr;
                    end else begin
                        s_next.status[`MCDL_ST_OVER] = 1'b1;
                    end
                end
                case (s_reg.config_r[`MCDL_CF_IRQSEL_HI:`MCDL_CF_IRQSEL_LO])
                    `MCDL_IRQ_LOCAL: s_next.irq_local = 1'b1;
                    `MCDL_IRQ_SMI:   s_next.irq_smi = 1'b1;
                    default: ;
                endcase
            end else begin
                // Primary only; deferred record left alone
                s_next.status = make_status(err_i, cap);
                s_next.status[`MCDL_ST_OVER] = s_reg.status[`MCDL_ST_VALID];
                s_next.addr = err_i.addr;
                if (err_i.kind == MCDL_CORRECTED) begin
                    s_next.ce_count = s_reg.ce_count + 16'd1;
                    if (s_reg.config_r[`MCDL_CF_INTEN] && s_reg.thresh != '0 &&
                        s_reg.ce_count + 16'd1 == s_reg.thresh) begin
                        s_next.irq_thresh = 1'b1;
                    end
                end
            end
            if (enabled && err_i.kind == MCDL_UNCORRECTED) begin
                s_next.core = next_core(s_reg.core, s_reg.mc_exception_enable);
            end
        end
    end

    // ****************************************
    // State register; warm reset spares the logs
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_reg <= '0;
            s_reg.config_r[`MCDL_CF_DEFLOG_SUP] <= 1'b1;
        end else if (warm_i) begin
            s_reg.bank_ctl <= `MCDL_RST_CTL;
            s_reg.gctl <= `MCDL_RST_CTL;
            s_reg.mc_exception_enable <= 1'b0;
            s_reg.core <= MCDL_RUN;
            s_reg.thresh <= `MCDL_RST_THRESH;
            s_reg.wb <= '0;
            s_reg.irq_local <= 1'b0;
            s_reg.irq_smi <= 1'b0;
            s_reg.irq_thresh <= 1'b0;
        end else begin
            s_reg <= s_next;
            s_reg.config_r[`MCDL_CF_ERRCODE_CAP] <= ERRCODE_CAP;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign wb_ack_o       = s_reg.wb.ack;
    assign wb_dat_o       = s_reg.wb.dat;
    assign mc_exception_o = s_reg.core == MCDL_EXC;
    assign shutdown_o     = s_reg.core == MCDL_SHUTDOWN;
    assign irq_local_o    = s_reg.irq_local;
    assign irq_smi_o      = s_reg.irq_smi;
    assign irq_thresh_o   = s_reg.irq_thresh;

endmodule
`default_nettype wire

// [tb/mcdl_chk.sv]
// Port checker for the deferred-error logging bank.
// Assumes one clock domain and binding onto mcdl_bank.
`timescale 1ns/100ps
`default_nettype none
module mcdl_chk
    import mcdl_pkg::*;
(
    input wire logic      clk_i,
    input wire logic      rst_i,
    input wire logic      warm_i,
    input wire logic      wb_cyc_i,
    input wire logic      wb_stb_i,
    input wire logic      wb_ack_o,
    input wire mcdl_err_t err_i,
    input wire logic      mc_exception_o,
    input wire logic      shutdown_o,
    input wire logic      irq_local_o,
    input wire logic      irq_smi_o,
    input wire logic      irq_thresh_o
);
    logic       errv_q;
    logic [1:0] kind_q;

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // Last cycle's error event
    always_ff @(posedge clk_i) begin
        errv_q <= err_i.valid;
        kind_q <= err_i.kind;
    end

    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_unc_prev;
        errv_q && kind_q == MCDL_UNCORRECTED;
    endsequence

    a_ack_after_req:
        assert property (s_req |=> wb_ack_o) else $error("request not acked");
    a_ack_one_cycle:
        assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
    a_exc_cause:
        assert property ($rose(mc_exception_o) |-> s_unc_prev) else $error("exception without cause");
    a_shut_cause:
        assert property ($rose(shutdown_o) |-> s_unc_prev) else $error("shutdown without cause");
    a_shut_sticky:
        assert property (shutdown_o && !warm_i |=> shutdown_o) else $error("shutdown dropped");
    a_warm_quiet:
        assert property (warm_i |=> !shutdown_o && !mc_exception_o) else $error("warm left escalation");
    a_defer_irq:
        assert property (irq_local_o || irq_smi_o |->
            errv_q && kind_q == MCDL_DEFERRED && !(irq_local_o && irq_smi_o))
            else $error("deferred irq wrong");
    a_thresh_irq:
        assert property (irq_thresh_o |-> errv_q && kind_q == MCDL_CORRECTED)
            else $error("threshold irq without corrected error");
endmodule

bind mcdl_bank mcdl_chk u_chk (.clk_i, .rst_i, .warm_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
    .err_i, .mc_exception_o, .shutdown_o, .irq_local_o, .irq_smi_o, .irq_thresh_o);
`default_nettype wire

// [tb/mcdl_err_src.sv]
// Model of an on-chip error detector feeding the bank.
// Assumes the bench calls fire; payload is scrambled outside the pulse.
`timescale 1ns/100ps
`default_nettype none
module mcdl_err_src
    import mcdl_pkg::*;
(
    input wire logic      clk_i,
    output var mcdl_err_t err_o
);
    initial err_o = '0;

    task automatic fire(input logic [1:0] k, input logic [31:0] c, input logic [63:0] a);
        @(posedge clk_i);
        err_o <= '{1'b1, k, 1'b1, 1'b1, c, a, ~a, a};
        @(posedge clk_i);
        err_o <= {1'b0, ~err_o[$bits(mcdl_err_t)-2:0]};
    endtask
endmodule
`default_nettype wire

// [tb/testbench.sv]
// Self-checking bench for the deferred-error logging bank.
// Assumes a 40 MHz clock and register access over classic Wishbone.
`timescale 1ns/100ps
`default_nettype none
`include "mcdl_consts.svh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
    $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module testbench
    import mcdl_pkg::*;
;
    localparam int BANK_COUNT = 3;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        warm_i = 1'b0;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] dat_w = 32'h0000_0000;
    logic [31:0] rdat;
    logic        ack, exc, shut, irq_l, irq_s, irq_t;
    mcdl_err_t   err;
    logic [63:0] v, m;
    int          n_errors = 0;
    int          n_compared = 0;

    mcdl_err_src SRC (.clk_i(clk_i), .err_o(err));
    mcdl_bank #(.BANK_COUNT(BANK_COUNT)) DUT (.clk_i(clk_i), .rst_i(rst_i), .warm_i(warm_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
        .wb_dat_i(dat_w), .wb_dat_o(rdat), .wb_ack_o(ack), .err_i(err),
        .mc_exception_o(exc), .shutdown_o(shut), .irq_local_o(irq_l), .irq_smi_o(irq_s),
        .irq_thresh_o(irq_t));

    initial forever #12.5 clk_i = ~clk_i;

    task automatic end_sim();
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // ****************************************
    // Bus access tasks
    // ****************************************
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat_w <= d;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (ack !== 1'b1) begin
            n_errors++;
            end_sim();
        end
        v = {rdat, v[63:32]};
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic wr64(input logic [7:0] i, input logic [63:0] d);
        wb(1'b1, {i[6:0], 1'b0}, d[31:0]);
        wb(1'b1, {i[6:0], 1'b1}, d[63:32]);
    endtask
    task automatic rd64(input logic [7:0] i);
        wb(1'b0, {i[6:0], 1'b0}, 32'h0000_0000);
        wb(1'b0, {i[6:0], 1'b1}, 32'h0000_0000);
    endtask
    task automatic fire(input logic [1:0] k, input logic [63:0] a);
        SRC.fire(k, 32'h1234_5678, a);
        #1;
    endtask

    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        rd64(`MCDL_IDX_BANK_CTL);  `CHK("bank_ctl", 64'h0, v)
        rd64(`MCDL_IDX_GCAP);      `CHK("bank_cnt", 8'(BANK_COUNT), v[7:0])
        `CHK("ctl_present", 1'b1, v[`MCDL_GCAP_GLOBAL_CTL_PRESENT])
        rd64(8'h07);               `CHK("unmapped", 64'h0, v)
        fire(MCDL_DEFERRED, 64'h0);
        rd64(`MCDL_IDX_DESTAT);    `CHK("destat_off", 64'h0, v)
        wr64(`MCDL_IDX_BANK_CTL, 64'hFFFF_FFFF_FFFF_FFFF);
        wr64(`MCDL_IDX_GCTL, 64'hFFFF_FFFF_FFFF_FFFF);
        wr64(`MCDL_IDX_CONFIG, 64'h0000_0120_0000_0000);
        wr64(`MCDL_IDX_CORE, 64'h1);
        rd64(`MCDL_IDX_CONFIG);    `CHK("errcode_cap", 1'b1, v[7])
        fire(MCDL_DEFERRED, 64'h0000_00AB_CDEF_0040);
        `CHK("irq_local", 1'b1, irq_l)
        rd64(`MCDL_IDX_DESTAT);    `CHK("destat", 64'h8420_1000_1234_5678, v)
        rd64(`MCDL_IDX_DEADDR);    `CHK("deaddr", 64'h0000_00AB_CDEF_0040, v)
        rd64(`MCDL_IDX_SYND1);     `CHK("synd1", ~64'h0000_00AB_CDEF_0040, v)
        rd64(`MCDL_IDX_STATUS);    `CHK("prim_valid", 1'b0, v[63])
        rd64(`MCDL_IDX_MISC1);
        m = v;
        wr64(`MCDL_IDX_MISC1, 64'hFFFF_FFFF_FFFF_FFFF);
        rd64(`MCDL_IDX_MISC1);     `CHK("misc1_ro", m, v)
        fire(MCDL_UNCORRECTED, 64'h0);
        `CHK("exception", 1'b1, exc)
        rd64(`MCDL_IDX_DESTAT);    `CHK("destat_kept", 64'h8420_1000_1234_5678, v)
        fire(MCDL_DEFERRED, 64'h0);
        rd64(`MCDL_IDX_DESTAT);    `CHK("destat_over", 64'hC420_1000_1234_5678, v)
        wr64(`MCDL_IDX_CORE, 64'h4);
        fire(MCDL_UNCORRECTED, 64'h0);
        `CHK("shutdown", 1'b1, shut)
        @(posedge clk_i);
        warm_i <= 1'b1;
        @(posedge clk_i);
        warm_i <= 1'b0;
        rd64(`MCDL_IDX_BANK_CTL);  `CHK("ctl_warm", 64'h0, v)
        `CHK("shut_warm", 1'b0, shut)
        rd64(`MCDL_IDX_DESTAT);    `CHK("destat_warm", 64'hC420_1000_1234_5678, v)
        wr64(`MCDL_IDX_DESTAT, 64'h0);
        wr64(`MCDL_IDX_STATUS, 64'h0);
        rd64(`MCDL_IDX_DESTAT);    `CHK("destat_clr", 64'h0, v)
        rd64(`MCDL_IDX_STATUS);    `CHK("status_clr", 64'h0, v)
        wr64(`MCDL_IDX_BANK_CTL, 64'hFFFF_FFFF_FFFF_FFFF);
        wr64(`MCDL_IDX_GCTL, 64'hFFFF_FFFF_FFFF_FFFF);
        wr64(`MCDL_IDX_CONFIG, 64'h0000_0144_0000_0000);
        fire(MCDL_DEFERRED, 64'h0);
        `CHK("irq_smi", 1'b1, irq_s)
        rd64(`MCDL_IDX_STATUS);    `CHK("dual_log", 2'b11, {v[63], v[44]})
        fire(MCDL_DEFERRED, 64'h0);
        rd64(`MCDL_IDX_STATUS);    `CHK("dual_over", 1'b1, v[62])
        wr64(`MCDL_IDX_THRESH, 64'h1);
        fire(MCDL_CORRECTED, 64'h0);
        `CHK("irq_thresh", 1'b1, irq_t)
        wr64(`MCDL_IDX_CONFIG, 64'h0);
        fire(MCDL_DEFERRED, 64'h0);
        `CHK("irq_none", 2'b00, {irq_l, irq_s})
        end_sim();
    end
endmodule
`default_nettype wire
